/* File: core/spar_pkg.sv */
package spar_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] SPAR_IDX_PWR = 8'h87;
   localparam logic [7:0] SPAR_IDX_SERIAL_CONTROL_REG = 8'h98;
   localparam logic [7:0] SPAR_IDX_SERIAL_BUFFER = 8'h99;
   localparam logic [7:0] SPAR_IDX_SLAVE_ADDRESS = 8'ha9;
   localparam logic [7:0] SPAR_IDX_SMASK = 8'hb9;
   // Serial control bit positions
   localparam int SPAR_SC_MODELO = 7;
   localparam int SPAR_SC_MODEHI = 6;
   localparam int SPAR_SC_MPE = 5;
   localparam int SPAR_SC_REN = 4;
   localparam int SPAR_SC_TB8 = 3;
   localparam int SPAR_SC_RB8 = 2;
   localparam int SPAR_SC_TI = 1;
   localparam int SPAR_SC_RI = 0;
   // Power control bit positions
   localparam int SPAR_PC_BDBL = 7;
   localparam int SPAR_PC_EVS = 6;
   // Reset values
   localparam logic [7:0] SPAR_RST_SLAVE_ADDRESS = 8'h00;
   localparam logic [7:0] SPAR_RST_SMASK = 8'h00;
   localparam logic [7:0] SPAR_RST_BYTE = 8'h00;
   // Mode codes {mode_select_hi, mode_select_lo}
   localparam logic [1:0] SPAR_MODE0 = 2'h0;
   localparam logic [1:0] SPAR_MODE1 = 2'h1;
   localparam logic [1:0] SPAR_MODE2 = 2'h2;
   // Frame lengths in bits
   localparam logic [3:0] SPAR_LEN_M1 = 4'ha;
   localparam logic [3:0] SPAR_LEN_M23 = 4'hb;
   localparam logic [3:0] SPAR_LEN_M0 = 4'h8;
   // Mode 0 bit period, clock fall and rise phases (fast / slow)
   localparam logic [3:0] SPAR_M0_PER_F = 4'h4;
   localparam logic [3:0] SPAR_M0_FALL_F = 4'h1;
   localparam logic [3:0] SPAR_M0_RISE_F = 4'h3;
   localparam logic [3:0] SPAR_M0_PER_S = 4'hc;
   localparam logic [3:0] SPAR_M0_FALL_S = 4'h3;
   localparam logic [3:0] SPAR_M0_RISE_S = 4'h9;
   // Mode 2 clocks per sample tick minus one (32 or 64 clocks a bit)
   localparam logic [1:0] SPAR_M2_DIV_F = 2'h1;
   localparam logic [1:0] SPAR_M2_DIV_S = 2'h3;
   // Sample states and last state of the divide-by-16 counter
   localparam logic [3:0] SPAR_SMP_A = 4'h7;
   localparam logic [3:0] SPAR_SMP_B = 4'h8;
   localparam logic [3:0] SPAR_SMP_C = 4'h9;
   localparam logic [3:0] SPAR_SUB_LAST = 4'hf;
   // Bus responses
   localparam logic [1:0] SPAR_RESP_OKAY = 2'h0;
   localparam logic [1:0] SPAR_RESP_SLVERR = 2'h2;
endpackage

/* File: core/spar_serial_port.sv */
`timescale 1ns/1ps
`default_nettype none
module spar_serial_port import spar_pkg::*; #(
   parameter int ADDR_W = 10
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // AXI4-Lite write address and data
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // AXI4-Lite write response
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // AXI4-Lite read
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // Baud timer overflow, same clock domain
   input wire logic timerOverflow,
   // Serial pins
   output logic txd,
   input wire logic rxdIn,
   output logic rxdOut,
   output logic rxdOe
);
   typedef struct packed {
      logic awready, wready, bvalid, arready, rvalid;
      logic [1:0] bresp, rresp;
      logic [31:0] rdata;
      logic awHeld, wHeld, wLane0;
      logic modeLo, modeHi, mpe, ren, tb8, rb8, ti, ri, fe, evs, bdbl;
      logic [7:0] awIdx, wData, slave_address, smask, serial_buffer, m0Sh;
      logic [1:0] div;
      logic ovfPh, txBusy, txd;
      logic [10:0] txSh;
      logic rxMeta, rxSync, rxPrev, rxBusy, smp1, smp2;
      logic [3:0] txSub, txCnt, rxSub, rxIdx, m0Ph, m0Bits;
      logic [9:0] rxSh;
      logic m0Act, m0Rx, rxdOut, rxdOe;
   } spar_state_t;
   spar_state_t r_ff, nxt_r;
   logic [1:0] mode;
   logic tick, doWrite, sbufWrite, stopEvt, vote, addrHit, loadOk, abortEvt;
   logic [3:0] lastIdx, m0Per, m0Fall, m0Rise;
   logic [7:0] rxByte, bcast, scRead;
   // Frame decode from the mode bits
   assign mode = {r_ff.modeHi, r_ff.modeLo};
   assign lastIdx = (mode == SPAR_MODE1) ? SPAR_LEN_M1 - 4'h1 : SPAR_LEN_M23 - 4'h1;
   assign m0Per = r_ff.mpe ? SPAR_M0_PER_F : SPAR_M0_PER_S;
   assign m0Fall = r_ff.mpe ? SPAR_M0_FALL_F : SPAR_M0_FALL_S;
   assign m0Rise = r_ff.mpe ? SPAR_M0_RISE_F : SPAR_M0_RISE_S;
   assign rxByte = r_ff.rxSh[7:0];
   // Given address and broadcast address
   assign bcast = r_ff.slave_address | r_ff.smask;
   assign addrHit = (((rxByte ^ r_ff.slave_address) & r_ff.smask) == 8'h00) || ((rxByte & bcast) == bcast);
   assign scRead = {(r_ff.evs ? r_ff.fe : r_ff.modeLo), r_ff.modeHi, r_ff.mpe, r_ff.ren,
                    r_ff.tb8, r_ff.rb8, r_ff.ti, r_ff.ri};
   assign doWrite = r_ff.awHeld && r_ff.wHeld && !r_ff.bvalid;
   assign sbufWrite = doWrite && r_ff.wLane0 && (r_ff.awIdx == SPAR_IDX_SERIAL_BUFFER);

   // Sample tick at 16x the bit rate in the async modes; no tick in mode 0
   // baud per mode
   always_comb begin
      unique case (mode)
         SPAR_MODE0: tick = 1'b0;
         SPAR_MODE2: tick = (r_ff.div == (r_ff.bdbl ? SPAR_M2_DIV_F : SPAR_M2_DIV_S));
         default: tick = timerOverflow && (r_ff.bdbl || r_ff.ovfPh);
      endcase
   end

   // Next state: bus first, then hardware, so hardware sets win
   always_comb begin
      nxt_r = r_ff;
      stopEvt = 1'b0;
      abortEvt = 1'b0;
      vote = 1'b0;
      loadOk = 1'b0;
      // Pin synchroniser and edge history
      nxt_r.rxMeta = rxdIn;
      nxt_r.rxSync = r_ff.rxMeta;
      nxt_r.rxPrev = r_ff.rxSync;
      // Baud dividers
      nxt_r.div = (mode == SPAR_MODE2 && tick) ? 2'h0 : r_ff.div + 2'h1;
      if (timerOverflow) begin
         nxt_r.ovfPh = !r_ff.ovfPh;
      end
      // Address and data channels taken in either order
      if (s_axi_awvalid && r_ff.awready) begin
         nxt_r.awHeld = 1'b1;
         nxt_r.awIdx = s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && r_ff.wready) begin
         nxt_r.wHeld = 1'b1;
         nxt_r.wData = s_axi_wdata[7:0];
         nxt_r.wLane0 = s_axi_wstrb[0];
      end
      if (r_ff.bvalid && s_axi_bready) begin
         nxt_r.bvalid = 1'b0;
      end
      // Register write
      if (doWrite) begin
         nxt_r.awHeld = 1'b0;
         nxt_r.wHeld = 1'b0;
         nxt_r.bvalid = 1'b1;
         nxt_r.bresp = SPAR_RESP_OKAY;
         if (r_ff.wLane0) begin
            unique case (r_ff.awIdx)
               SPAR_IDX_SERIAL_CONTROL_REG: begin
                  if (r_ff.evs) begin
                     if (!r_ff.wData[SPAR_SC_MODELO]) nxt_r.fe = 1'b0;
                  end else begin
                     nxt_r.modeLo = r_ff.wData[SPAR_SC_MODELO];
                  end
                  nxt_r.modeHi = r_ff.wData[SPAR_SC_MODEHI];
                  nxt_r.mpe = r_ff.wData[SPAR_SC_MPE];
                  nxt_r.ren = r_ff.wData[SPAR_SC_REN];
                  nxt_r.tb8 = r_ff.wData[SPAR_SC_TB8];
                  nxt_r.rb8 = r_ff.wData[SPAR_SC_RB8];
                  nxt_r.ti = r_ff.wData[SPAR_SC_TI];
                  nxt_r.ri = r_ff.wData[SPAR_SC_RI];
               end
               SPAR_IDX_PWR: begin
                  nxt_r.bdbl = r_ff.wData[SPAR_PC_BDBL];
                  nxt_r.evs = r_ff.wData[SPAR_PC_EVS];
               end
               SPAR_IDX_SERIAL_BUFFER: ;
               SPAR_IDX_SLAVE_ADDRESS: nxt_r.slave_address = r_ff.wData;
               SPAR_IDX_SMASK: nxt_r.smask = r_ff.wData;
               default: nxt_r.bresp = SPAR_RESP_SLVERR;
            endcase
         end
      end
      // Register read
      if (r_ff.rvalid && s_axi_rready) begin
         nxt_r.rvalid = 1'b0;
      end
      if (s_axi_arvalid && r_ff.arready) begin
         nxt_r.rvalid = 1'b1;
         nxt_r.rresp = SPAR_RESP_OKAY;
         unique case (s_axi_araddr[9:2])
            SPAR_IDX_SERIAL_CONTROL_REG: nxt_r.rdata = {24'h000000, scRead};
            SPAR_IDX_PWR: nxt_r.rdata = {24'h000000, r_ff.bdbl, r_ff.evs, 6'h00};
            SPAR_IDX_SERIAL_BUFFER: nxt_r.rdata = {24'h000000, r_ff.serial_buffer};
            SPAR_IDX_SLAVE_ADDRESS: nxt_r.rdata = {24'h000000, r_ff.slave_address};
            SPAR_IDX_SMASK: nxt_r.rdata = {24'h000000, r_ff.smask};
            default: begin
               nxt_r.rdata = 32'h00000000;
               nxt_r.rresp = SPAR_RESP_SLVERR;
            end
         endcase
      end
      nxt_r.awready = !nxt_r.awHeld && !nxt_r.bvalid;
      nxt_r.wready = !nxt_r.wHeld && !nxt_r.bvalid;
      nxt_r.arready = !nxt_r.rvalid;

      if (mode == SPAR_MODE0) begin
         // Mode 0: half-duplex shift, clock on the transmit pin
         nxt_r.rxBusy = 1'b0;
         nxt_r.txBusy = 1'b0;
         if (!r_ff.m0Act) begin
            nxt_r.txd = 1'b1;
            nxt_r.rxdOe = 1'b0;
            if (sbufWrite) begin
               nxt_r.m0Act = 1'b1;
               nxt_r.m0Rx = 1'b0;
               nxt_r.m0Sh = r_ff.wData;
               nxt_r.m0Ph = 4'h0;
               nxt_r.m0Bits = 4'h0;
            end else if (r_ff.ren && !r_ff.ri) begin
               nxt_r.m0Act = 1'b1;
               nxt_r.m0Rx = 1'b1;
               nxt_r.m0Ph = 4'h0;
               nxt_r.m0Bits = 4'h0;
            end
         end else begin
            nxt_r.m0Ph = (r_ff.m0Ph == m0Per - 4'h1) ? 4'h0 : r_ff.m0Ph + 4'h1;
            if (r_ff.m0Ph == 4'h0) begin
               nxt_r.rxdOut = r_ff.m0Sh[0];
               nxt_r.rxdOe = !r_ff.m0Rx;
            end
            if (r_ff.m0Ph == m0Fall) nxt_r.txd = 1'b0;
            if (r_ff.m0Ph == m0Rise) begin
               nxt_r.txd = 1'b1;
               nxt_r.m0Sh = {r_ff.rxSync, r_ff.m0Sh[7:1]};
               nxt_r.m0Bits = r_ff.m0Bits + 4'h1;
               if (r_ff.m0Bits == SPAR_LEN_M0 - 4'h1) begin
                  nxt_r.m0Act = 1'b0;
                  nxt_r.rxdOe = 1'b0;
                  if (r_ff.m0Rx) begin
                     nxt_r.serial_buffer = {r_ff.rxSync, r_ff.m0Sh[7:1]};
                     nxt_r.ri = 1'b1;
                  end else begin
                     nxt_r.ti = 1'b1;
                  end
               end
            end
         end
      end else begin
         nxt_r.m0Act = 1'b0;
         nxt_r.rxdOe = 1'b0;
         // Async transmit, paced by its own divide-by-16 counter
         // buffer write starts send
         if (sbufWrite && !r_ff.txBusy) begin
            nxt_r.txBusy = 1'b1;
            nxt_r.txSub = 4'h0;
            nxt_r.txSh = (mode == SPAR_MODE1) ? {2'h3, r_ff.wData, 1'b0} : {1'b1, r_ff.tb8, r_ff.wData, 1'b0};
            nxt_r.txCnt = (mode == SPAR_MODE1) ? SPAR_LEN_M1 : SPAR_LEN_M23;
         end else if (r_ff.txBusy && tick) begin
            nxt_r.txSub = r_ff.txSub + 4'h1;
            if (r_ff.txSub == SPAR_SUB_LAST) begin
               nxt_r.txd = r_ff.txSh[0];
               nxt_r.txSh = {1'b1, r_ff.txSh[10:1]};
               nxt_r.txCnt = r_ff.txCnt - 4'h1;
               if (r_ff.txCnt == 4'h1) begin
                  nxt_r.txBusy = 1'b0;
                  nxt_r.ti = 1'b1;
               end
            end
         end else if (!r_ff.txBusy) begin
            nxt_r.txd = 1'b1;
         end
         // start on falling edge when enabled
         if (!r_ff.rxBusy) begin
            if (r_ff.ren && r_ff.rxPrev && !r_ff.rxSync) begin
               nxt_r.rxBusy = 1'b1;
               nxt_r.rxSub = 4'h0;
               nxt_r.rxIdx = 4'h0;
            end
         end else if (tick) begin
            nxt_r.rxSub = r_ff.rxSub + 4'h1;
            if (r_ff.rxSub == SPAR_SMP_A) nxt_r.smp1 = r_ff.rxSync;
            if (r_ff.rxSub == SPAR_SMP_B) nxt_r.smp2 = r_ff.rxSync;
            if (r_ff.rxSub == SPAR_SMP_C) begin
               vote = (r_ff.smp1 & r_ff.smp2) | (r_ff.smp1 & r_ff.rxSync) | (r_ff.smp2 & r_ff.rxSync);
               nxt_r.rxIdx = r_ff.rxIdx + 4'h1;
               if (r_ff.rxIdx == 4'h0) begin
                  // False start bit aborts at once
                  abortEvt = vote;
                  nxt_r.rxBusy = !vote;
               end else if (r_ff.rxIdx == lastIdx) begin
                  stopEvt = 1'b1;
                  nxt_r.rxBusy = 1'b0;
                  loadOk = !r_ff.ri && (!r_ff.mpe ||
                           (addrHit && ((mode == SPAR_MODE1) ? vote : r_ff.rxSh[8]) && vote));
                  if (loadOk) begin
                     nxt_r.serial_buffer = rxByte;
                     nxt_r.rb8 = (mode == SPAR_MODE1) ? vote : r_ff.rxSh[8];
                     nxt_r.ri = 1'b1;
                  end
                  if (!vote) nxt_r.fe = 1'b1;
               end else begin
                  nxt_r.rxSh[4'(r_ff.rxIdx - 4'h1)] = vote;
               end
            end
         end
      end
   end

   // State register, synchronous reset
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         r_ff <= '0;
         r_ff.awready <= 1'b1;
         r_ff.wready <= 1'b1;
         r_ff.arready <= 1'b1;
         r_ff.txd <= 1'b1;
         r_ff.rxMeta <= 1'b1;
         r_ff.rxSync <= 1'b1;
         r_ff.rxPrev <= 1'b1;
         r_ff.slave_address <= SPAR_RST_SLAVE_ADDRESS;
         r_ff.smask <= SPAR_RST_SMASK;
         r_ff.serial_buffer <= SPAR_RST_BYTE;
      end else begin
         r_ff <= nxt_r;
      end
   end

   // Outputs straight from the state register
   assign s_axi_awready = r_ff.awready;
   assign s_axi_wready = r_ff.wready;
   assign s_axi_bvalid = r_ff.bvalid;
   assign s_axi_bresp = r_ff.bresp;
   assign s_axi_arready = r_ff.arready;
   assign s_axi_rvalid = r_ff.rvalid;
   assign s_axi_rdata = r_ff.rdata;
   assign s_axi_rresp = r_ff.rresp;
   assign txd = r_ff.txd;
   assign rxdOut = r_ff.rxdOut;
   assign rxdOe = r_ff.rxdOe;

   // Checks on the block's own behaviour
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   fe_sticky_a: assert property (r_ff.fe && !(doWrite && r_ff.awIdx == SPAR_IDX_SERIAL_CONTROL_REG && r_ff.evs) |=> r_ff.fe)
      else $error("frame error cleared without software");
   fe_on_stop_a: assert property (stopEvt && !vote |=> r_ff.fe)
      else $error("low stop sample did not flag error");
   addr_reset_a: assert property ($past(srst) |-> r_ff.slave_address == 8'h00 && r_ff.smask == 8'h00)
      else $error("address registers not zero after reset");
   tx_start_a: assert property (sbufWrite && mode != SPAR_MODE0 && !r_ff.txBusy |=> r_ff.txBusy)
      else $error("buffer write did not start transmit");
   rx_all_a: assert property (stopEvt && !r_ff.ri && !r_ff.mpe |=> r_ff.ri && r_ff.serial_buffer == $past(rxByte))
      else $error("frame not delivered with multiproc off");
   mp_filter_a: assert property (stopEvt && r_ff.mpe && !addrHit |=> $stable(r_ff.serial_buffer))
      else $error("unmatched address loaded");
   ri_block_a: assert property (stopEvt && r_ff.ri |=> $stable(r_ff.serial_buffer))
      else $error("frame loaded over pending done flag");
   m0_rx_start_a: assert property (mode == SPAR_MODE0 && !r_ff.m0Act && r_ff.ren && !r_ff.ri && !sbufWrite
      && !(doWrite && r_ff.awIdx == SPAR_IDX_SERIAL_CONTROL_REG) |=> r_ff.m0Act && r_ff.m0Rx)
      else $error("mode 0 receive did not start");
   view_sel_a: assert property (s_axi_arvalid && r_ff.arready && s_axi_araddr[9:2] == SPAR_IDX_SERIAL_CONTROL_REG
      |=> s_axi_rdata[7] == ($past(r_ff.evs) ? $past(r_ff.fe) : $past(r_ff.modeLo)))
      else $error("shared bit shows wrong flag");
   start_abort_a: assert property (abortEvt |=> !r_ff.rxBusy ##1 !r_ff.rxBusy || (r_ff.rxIdx == 4'h0))
      else $error("false start not aborted");
   bvalid_hold_a: assert property (r_ff.bvalid && !s_axi_bready |=> r_ff.bvalid)
      else $error("write response dropped early");

   tx_done_c: cover property (r_ff.txBusy ##1 !r_ff.txBusy && r_ff.ti);
   rx_load_c: cover property (loadOk);
   fe_set_c: cover property (!r_ff.fe ##1 r_ff.fe);
   m0_rx_c: cover property (r_ff.m0Act && r_ff.m0Rx ##1 !r_ff.m0Act);
endmodule // spar_serial_port
`default_nettype wire

/* File: verif/spar_far_end.sv */
`timescale 1ns/1ps
`default_nettype none
module spar_far_end (
   // Clock
   input wire logic clk,
   // Device serial pins
   input wire logic txd,
   input wire logic rxdOut,
   input wire logic rxdOe,
   // Resolved data line
   output logic rxdLine
);
   localparam int BIT_CLKS = 32;
   logic drvBit = 1'h1;
   logic m0En = 1'h0;
   logic [7:0] m0Data = 8'h00;
   logic txdPrev = 1'h1;
   // Device drive wins; a released line carries the far end's drvBit
   assign rxdLine = rxdOe ? rxdOut : drvBit;
   always @(posedge clk) begin
      txdPrev <= txd;
      if (m0En && txdPrev && !txd) begin
         drvBit <= m0Data[0];
         m0Data <= {1'h1, m0Data[7:1]};
      end
   end
   // Shift-mode data source, armed before the device enables reception
   task automatic m0_load(input logic [7:0] d);
      m0Data <= d;
      m0En <= 1'h1;
   endtask
   task automatic m0_release();
      m0En <= 1'h0;
      drvBit <= 1'h1;
   endtask
   task automatic send(input logic [10:0] bits);
      for (int i = 0; i < 13; i++) begin
         drvBit <= (i < 11) ? bits[i] : 1'h1;
         repeat (BIT_CLKS) @(posedge clk);
      end
   endtask
   // Mid-bit sampling; tolerates a start bit that began a few clocks early
   task automatic catch_frame(output logic [10:0] bits);
      while (txd !== 1'h0) @(posedge clk);
      repeat (BIT_CLKS / 2) @(posedge clk);
      for (int i = 0; i < 11; i++) begin
         bits[i] = txd;
         repeat (BIT_CLKS) @(posedge clk);
      end
   endtask
endmodule // spar_far_end
`default_nettype wire

/* File: verif/tb_serial_port_addr_recog.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_serial_port_addr_recog import spar_pkg::*;;
   // Clock, reset, baud source and bus requests
   logic refClk = 1'h0;
   logic srst = 1'h1;
   logic timerOverflow = 1'h0;
   logic awValid = 1'h0, wValid = 1'h0, bReady = 1'h0, arValid = 1'h0, rReady = 1'h0;
   logic [9:0] awAddr = 10'h000, arAddr = 10'h000;
   logic [31:0] wData = 32'h0;
   // Design answers and pins
   logic awReady, wReady, bValid, arReady, rValid, txd, rxdLine, rxdOut, rxdOe;
   logic [1:0] bResp, rResp, resp;
   logic [31:0] rData, v;
   // Bookkeeping
   int errorCnt = 0;
   int checksDone = 0;
   logic [7:0] serial_control_reg, txb;
   logic [7:0] bufExp = 8'h00;
   logic rb8Exp = 1'h0;
   logic [15:0] c;
   logic [10:0] frm, got;
   // Receive cases: mode, {multiproc, ninth, stop, expect done}, byte
   logic [15:0] rxCases [13] = '{16'h1_3_3c, 16'h2_3_a5, 16'h3_7_0f, 16'h2_5_c3, 16'h2_f_13,
      16'h2_e_a2, 16'h2_f_a0, 16'h2_f_fe, 16'h2_a_a5, 16'h1_8_a5, 16'h1_b_a5, 16'h3_e_a7, 16'h2_f_a4};
   // 10 MHz clock
   always #50 refClk = ~refClk;
   // Overflow every second clock, so every async mode runs 32 clocks a bit
   always @(posedge refClk) timerOverflow <= ~timerOverflow;
   spar_serial_port dut (
      .ref_clk(refClk),
      .srst(srst),
      .s_axi_awvalid(awValid),
      .s_axi_awready(awReady),
      .s_axi_awaddr(awAddr),
      .s_axi_wvalid(wValid),
      .s_axi_wready(wReady),
      .s_axi_wdata(wData),
      .s_axi_wstrb(4'h1),
      .s_axi_bvalid(bValid),
      .s_axi_bready(bReady),
      .s_axi_bresp(bResp),
      .s_axi_arvalid(arValid),
      .s_axi_arready(arReady),
      .s_axi_araddr(arAddr),
      .s_axi_rvalid(rValid),
      .s_axi_rready(rReady),
      .s_axi_rdata(rData),
      .s_axi_rresp(rResp),
      .timerOverflow(timerOverflow),
      .txd(txd),
      .rxdIn(rxdLine),
      .rxdOut(rxdOut),
      .rxdOe(rxdOe)
   );
   spar_far_end far (
      .clk(refClk),
      .txd(txd),
      .rxdOut(rxdOut),
      .rxdOe(rxdOe),
      .rxdLine(rxdLine)
   );
   // Compare and count
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp) begin
         errorCnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Write: address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] idx, input logic [7:0] val);
      awAddr <= {idx, 2'h0};
      wData <= {24'h0, val};
      awValid <= 1'h1;
      wValid <= 1'h1;
      do begin
         @(posedge refClk);
         if (awReady) awValid <= 1'h0;
         if (wReady) wValid <= 1'h0;
      end while ((awValid && !awReady) || (wValid && !wReady));
      // Ready raised late so back-to-back calls never assign it twice at one edge
      bReady <= 1'h1;
      do @(posedge refClk); while (bValid !== 1'h1);
      resp = bResp;
      bReady <= 1'h0;
   endtask
   // Read one word
   task automatic rd(input logic [7:0] idx, output logic [31:0] val);
      arAddr <= {idx, 2'h0};
      arValid <= 1'h1;
      do @(posedge refClk); while (arReady !== 1'h1);
      arValid <= 1'h0;
      rReady <= 1'h1;
      do @(posedge refClk); while (rValid !== 1'h1);
      val = rData;
      resp = rResp;
      rReady <= 1'h0;
   endtask
   // Verdict and end of run
   task automatic testDone();
      if (errorCnt == 0 && checksDone > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (3) @(posedge refClk);
      srst <= 1'h0;
      rd(SPAR_IDX_SLAVE_ADDRESS, v);
      chk("address reset", v, 32'h0);
      rd(SPAR_IDX_SMASK, v);
      chk("mask reset", v, 32'h0);
      rd(8'h10, v);
      chk("unmapped read", {30'h0, resp}, {30'h0, SPAR_RESP_SLVERR});
      wr(8'h10, 8'h55);
      chk("unmapped write", {30'h0, resp}, {30'h0, SPAR_RESP_SLVERR});
      wr(SPAR_IDX_PWR, 8'h80);
      // Receive table; address filter programmed after the five reset-state cases
      for (int i = 0; i < 13; i++) begin
         c = rxCases[i];
         if (i == 5) begin
            wr(SPAR_IDX_SLAVE_ADDRESS, 8'ha4);
            wr(SPAR_IDX_SMASK, 8'hfa);
            rd(SPAR_IDX_SMASK, v);
            chk("mask write", v, 32'hfa);
         end
         serial_control_reg = {c[12], c[13], c[11], 5'h10};
         wr(SPAR_IDX_SERIAL_CONTROL_REG, serial_control_reg);
         // Control write stores zero into rx_ninth_bit
         rb8Exp = 1'h0;
         frm = {c[9], c[10], c[7:0], 1'h0};
         if (c[13:12] == SPAR_MODE1) frm = {1'h1, c[9], c[7:0], 1'h0};
         far.send(frm);
         if (c[8]) begin
            bufExp = c[7:0];
            rb8Exp = (c[13:12] == SPAR_MODE1) ? c[9] : c[10];
         end
         rd(SPAR_IDX_SERIAL_CONTROL_REG, v);
         chk("rx control", v, {24'h0, serial_control_reg[7:3], rb8Exp, 1'h0, c[8]});
         rd(SPAR_IDX_SERIAL_BUFFER, v);
         chk("rx buffer", v, {24'h0, bufExp});
      end
      wr(SPAR_IDX_PWR, 8'hc0);
      rd(SPAR_IDX_SERIAL_CONTROL_REG, v);
      chk("error flag set", v, {24'h0, 1'h1, serial_control_reg[6:3], rb8Exp, 2'h1});
      wr(SPAR_IDX_PWR, 8'h80);
      rd(SPAR_IDX_SERIAL_CONTROL_REG, v);
      chk("mode bit view", v, {24'h0, serial_control_reg[7:3], rb8Exp, 2'h1});
      wr(SPAR_IDX_PWR, 8'hc0);
      wr(SPAR_IDX_SERIAL_CONTROL_REG, serial_control_reg);
      rb8Exp = 1'h0;
      rd(SPAR_IDX_SERIAL_CONTROL_REG, v);
      chk("error flag clear", v, {24'h0, serial_control_reg[7:3], rb8Exp, 2'h0});
      wr(SPAR_IDX_PWR, 8'h80);
      // Transmit in each async mode, ninth bit taken from control
      for (int m = 1; m < 4; m++) begin
         serial_control_reg = {m[0], m[1], 2'h0, m[0], 3'h0};
         txb = {6'h1a, m[1:0]};
         wr(SPAR_IDX_SERIAL_CONTROL_REG, serial_control_reg);
         wr(SPAR_IDX_SERIAL_BUFFER, txb);
         far.catch_frame(got);
         frm = (m == 1) ? {2'h3, txb, 1'h0} : {1'h1, m[0], txb, 1'h0};
         chk("tx frame", {21'h0, got}, {21'h0, frm});
         rd(SPAR_IDX_SERIAL_CONTROL_REG, v);
         chk("tx done", v, {24'h0, serial_control_reg[7:3], rb8Exp, 2'h2});
      end
      // Fast shift mode transmit: data driven, taken at each clock fall
      wr(SPAR_IDX_SERIAL_CONTROL_REG, 8'h20);
      wr(SPAR_IDX_SERIAL_BUFFER, 8'h6c);
      for (int b = 0; b < 8; b++) begin
         do @(posedge refClk); while (txd !== 1'h0);
         txb[b] = rxdOut;
         chk("shift tx enable", {31'h0, rxdOe}, 32'h1);
         do @(posedge refClk); while (txd !== 1'h1);
      end
      chk("shift tx byte", {24'h0, txb}, 32'h6c);
      // Slow shift mode: 8 bits of 12 clocks once enabled
      far.m0_load(8'hb4);
      wr(SPAR_IDX_SERIAL_CONTROL_REG, 8'h10);
      repeat (120) @(posedge refClk);
      rd(SPAR_IDX_SERIAL_CONTROL_REG, v);
      chk("shift rx done", v, {24'h0, 5'h02, rb8Exp, 2'h1});
      rd(SPAR_IDX_SERIAL_BUFFER, v);
      chk("shift rx byte", v, 32'hb4);
      wr(SPAR_IDX_SERIAL_CONTROL_REG, 8'h00);
      far.m0_release();
      testDone();
   end
   // Watchdog; the sequence needs about 7000 clocks
   initial begin
      repeat (40000) @(posedge refClk);
      errorCnt++;
      testDone();
   end
endmodule // tb_serial_port_addr_recog
`default_nettype wire
